// file: rh_regs_pkg.sv
// constants for the low-speed threshold and first root hub descriptor registers
// assumes a 32-bit AXI4-Lite register bus clocked by mclk
package rh_regs_pkg;
  localparam logic [7:0]  LS_THRESH_OFFSET = 8'h44;
  localparam logic [7:0]  RH_DESC_A_OFFSET = 8'h48;
  localparam logic [7:0]  CTRL_OFFSET      = 8'h50;
  localparam int          THRESH_MSB       = 11;
  localparam int          FRAME_MSB        = 13;
  localparam logic [11:0] THRESH_RESET     = 12'h628;
  localparam int          POWER_GOOD_LSB   = 24;
  localparam int          NO_OC_BIT        = 12;
  localparam int          OC_MODE_BIT      = 11;
  localparam int          COMPOUND_BIT     = 10;
  localparam int          ALWAYS_PWR_BIT   = 9;
  localparam int          SWITCH_MODE_BIT  = 8;
  localparam logic [7:0]  POWER_GOOD_RESET = 8'hff;
  localparam logic [7:0]  PORTS_TWO        = 8'h02;
  localparam logic [7:0]  PORTS_ONE        = 8'h01;
  localparam int          POWER_GOOD_UNIT_MS = 2;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage

// file: axil_if.sv
// write/read strobes between the bus slave and the register bank
// assumes one clock; strobes are one-cycle pulses
`timescale 1ns/1ps
interface axil_if;
  logic        wrEn;
  logic [7:0]  wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        wrHit;
  logic [7:0]  rdAddr;
  logic [31:0] rdData;
  logic        rdHit;
  modport slave (output wrEn, wrAddr, wrData, wrStrb, rdAddr,
                 input wrHit, rdData, rdHit);
  modport bank  (input wrEn, wrAddr, wrData, wrStrb, rdAddr,
                 output wrHit, rdData, rdHit);
endinterface

// file: axil_slave.sv
// AXI4-Lite slave front end, one write and one read outstanding
// assumes synchronous active-high reset; decode is done by the bank
`timescale 1ns/1ps
module axil_slave
  import rh_regs_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // register bank side
  axil_if.slave            regs
);
  logic        awHave_reg, awHave_next, wHave_reg, wHave_next;
  logic [7:0]  awAddr_reg, awAddr_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0]  wStrb_reg, wStrb_next;
  logic        bValid_reg, bValid_next, rValid_reg, rValid_next;
  logic [1:0]  bResp_reg, bResp_next, rResp_reg, rResp_next;
  logic [31:0] rData_reg, rData_next;
  logic        doWrite;

  // address and data taken in either order, response after both
  assign awready = !awHave_reg && !bValid_reg;
  assign wready  = !wHave_reg && !bValid_reg;
  assign arready = !rValid_reg;
  assign doWrite = awHave_reg && wHave_reg;
  assign regs.wrEn   = doWrite;
  assign regs.wrAddr = awAddr_reg;
  assign regs.wrData = wData_reg;
  assign regs.wrStrb = wStrb_reg;
  assign regs.rdAddr = araddr;
  assign bvalid = bValid_reg;
  assign bresp  = bResp_reg;
  assign rvalid = rValid_reg;
  assign rresp  = rResp_reg;
  assign rdata  = rData_reg;

  // next state of both channels
  always_comb begin
    awHave_next = awHave_reg;
    awAddr_next = awAddr_reg;
    wHave_next  = wHave_reg;
    wData_next  = wData_reg;
    wStrb_next  = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next  = bResp_reg;
    rValid_next = rValid_reg;
    rResp_next  = rResp_reg;
    rData_next  = rData_reg;
    if (awvalid && awready) begin
      awHave_next = 1'b1;
      awAddr_next = awaddr;
    end
    if (wvalid && wready) begin
      wHave_next = 1'b1;
      wData_next = wdata;
      wStrb_next = wstrb;
    end
    if (doWrite) begin
      awHave_next = 1'b0;
      wHave_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = regs.wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bValid_reg && bready) begin
      bValid_next = 1'b0;
    end
    if (arvalid && arready) begin
      rValid_next = 1'b1;
      rData_next  = regs.rdHit ? regs.rdData : 32'h0000_0000;
      rResp_next  = regs.rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_reg && rready) begin
      rValid_next = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge mclk) begin
    if (rst) begin
      awHave_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wHave_reg  <= 1'b0;
      wData_reg  <= 32'h0000_0000;
      wStrb_reg  <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg  <= 2'h0;
      rValid_reg <= 1'b0;
      rResp_reg  <= 2'h0;
      rData_reg  <= 32'h0000_0000;
    end else begin
      awHave_reg <= awHave_next;
      awAddr_reg <= awAddr_next;
      wHave_reg  <= wHave_next;
      wData_reg  <= wData_next;
      wStrb_reg  <= wStrb_next;
      bValid_reg <= bValid_next;
      bResp_reg  <= bResp_next;
      rValid_reg <= rValid_next;
      rResp_reg  <= rResp_next;
      rData_reg  <= rData_next;
    end
  end
endmodule

// file: lowspeed_threshold_roothub_desc_a.sv
// low-speed start threshold and first root hub descriptor register bank
// assumes AXI4-Lite master, frame counter and port-config strap on mclk
// Notes on behaviour
// - start low-speed only when remaining time >= threshold
// - power-good byte in 2 ms units, software waits
// - no-protection set means none; else mode selects
// - overcurrent mode resets equal to switch mode
// - port count read-only, reset by port configuration
// - mode one reports overcurrent per port
// - compound device bit always reads zero
// - switch mode: zero ganged, one per port
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module lowspeed_threshold_roothub_desc_a
  import rh_regs_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // port configuration strap, high for two ports
  input  wire logic        twoPortConfig,
  // low-speed start gate
  input  wire logic [13:0] frameTimeRemaining,
  input  wire logic        lowSpeedRequest,
  output logic             lowSpeedStart,
  // root hub policy outputs
  output logic [7:0]       powerGoodDelay,
  output logic             perPortOvercurrent,
  output logic             collectiveOvercurrent,
  output logic             perPortPower,
  output logic             gangedPower
);
  axil_if regs ();

  axil_slave busSlave (
    .mclk    (mclk),
    .rst     (rst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .regs    (regs)
  );

  logic [31:0] thresh_reg, thresh_next;
  logic [31:0] descA_reg, descA_next;
  logic        resetSeen_reg, resetSeen_next;
  logic [7:0]  portCount_reg, portCount_next;
  logic        startGate_reg, startGate_next;
  logic [31:0] descARead;

  // byte-lane merge of a write into a word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // read view: compound flag forced low, port count from strap
  always_comb begin
    descARead = descA_reg;
    descARead[COMPOUND_BIT] = 1'b0;
    descARead[7:0] = portCount_reg;
  end

  // decode; reserved bits are stored as written, software keeps them at reset
  always_comb begin
    thresh_next    = thresh_reg;
    descA_next     = descA_reg;
    resetSeen_next = 1'b1;
    portCount_next = portCount_reg;
    regs.wrHit     = 1'b0;
    regs.rdHit     = 1'b0;
    regs.rdData    = 32'h0000_0000;
    // strap caught on the first clock after reset release
    if (!resetSeen_reg) begin
      portCount_next = twoPortConfig ? PORTS_TWO : PORTS_ONE;
    end
    if (regs.wrAddr == LS_THRESH_OFFSET || regs.wrAddr == RH_DESC_A_OFFSET) begin
      regs.wrHit = 1'b1;
    end
    if (regs.wrEn && regs.wrAddr == LS_THRESH_OFFSET) begin
      thresh_next = merge(thresh_reg, regs.wrData, regs.wrStrb);
    end
    if (regs.wrEn && regs.wrAddr == RH_DESC_A_OFFSET) begin
      descA_next = merge(descA_reg, regs.wrData, regs.wrStrb);
    end
    if (regs.rdAddr == LS_THRESH_OFFSET) begin
      regs.rdHit  = 1'b1;
      regs.rdData = thresh_reg;
    end else if (regs.rdAddr == RH_DESC_A_OFFSET) begin
      regs.rdHit  = 1'b1;
      regs.rdData = descARead;
    end
  end

  // low-speed start decision, registered
  always_comb begin
    startGate_next = lowSpeedRequest &&
                     (frameTimeRemaining >= {2'b00, thresh_reg[THRESH_MSB:0]});
  end

  // state registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      thresh_reg    <= {20'h00000, THRESH_RESET};
      // overcurrent mode resets equal to switch mode: bits 11 and 8 both one
      // low byte is shadowed by the strap on reads, stored value unused
      descA_reg     <= {POWER_GOOD_RESET, 16'h0009, PORTS_ONE};
      resetSeen_reg <= 1'b0;
      portCount_reg <= PORTS_ONE;
      startGate_reg <= 1'b0;
    end else begin
      thresh_reg    <= thresh_next;
      descA_reg     <= descA_next;
      resetSeen_reg <= resetSeen_next;
      portCount_reg <= portCount_next;
      startGate_reg <= startGate_next;
    end
  end

  // policy outputs decoded from the descriptor
  assign lowSpeedStart  = startGate_reg;
  assign powerGoodDelay = descA_reg[31:POWER_GOOD_LSB];
  assign perPortOvercurrent =
    !descA_reg[NO_OC_BIT] && descA_reg[OC_MODE_BIT];
  assign collectiveOvercurrent =
    !descA_reg[NO_OC_BIT] && !descA_reg[OC_MODE_BIT];
  assign perPortPower = !descA_reg[ALWAYS_PWR_BIT] && descA_reg[SWITCH_MODE_BIT];
  assign gangedPower  = !descA_reg[ALWAYS_PWR_BIT] && !descA_reg[SWITCH_MODE_BIT];

  AST_LS_START: assert property (@(posedge mclk) disable iff (rst)
    lowSpeedRequest && frameTimeRemaining < {2'b00, thresh_reg[11:0]} |=> !lowSpeedStart)
    else $error("low-speed start below threshold");
  AST_LS_ALLOW: assert property (@(posedge mclk) disable iff (rst)
    lowSpeedRequest && frameTimeRemaining >= {2'b00, thresh_reg[11:0]} |=> lowSpeedStart)
    else $error("low-speed start withheld");
  AST_RESET_VAL: assert property (@(posedge mclk) $fell(rst) |->
    thresh_reg == 32'h0000_0628 && descA_reg[31:8] == 24'hff0009)
    else $error("bad reset values");
  AST_OC_MODE: assert property (@(posedge mclk) $fell(rst) |->
    descA_reg[OC_MODE_BIT] == descA_reg[SWITCH_MODE_BIT])
    else $error("overcurrent mode differs from switch mode at reset");
  AST_NO_OC: assert property (@(posedge mclk) disable iff (rst)
    descA_reg[NO_OC_BIT] |-> !perPortOvercurrent && !collectiveOvercurrent)
    else $error("overcurrent reported while unsupported");
  AST_PER_PORT: assert property (@(posedge mclk) disable iff (rst)
    regs.wrEn && regs.wrAddr == RH_DESC_A_OFFSET && regs.wrStrb[1] &&
    regs.wrData[12:11] == 2'b01 |=> perPortOvercurrent)
    else $error("per-port overcurrent not selected");
  AST_COMPOUND: assert property (@(posedge mclk) disable iff (rst)
    regs.rdAddr == RH_DESC_A_OFFSET |-> !regs.rdData[10])
    else $error("compound device bit read as one");
  AST_PORTS: assert property (@(posedge mclk) disable iff (rst)
    resetSeen_reg |=> $stable(portCount_reg))
    else $error("port count changed");
  AST_PWR_MODE: assert property (@(posedge mclk) disable iff (rst)
    !descA_reg[9] |-> perPortPower == descA_reg[8] && gangedPower != descA_reg[8])
    else $error("power switching mode mismatch");
  AST_POWER_GOOD: assert property (@(posedge mclk) disable iff (rst)
    regs.wrEn && regs.wrAddr == RH_DESC_A_OFFSET && regs.wrStrb[3] |=>
    powerGoodDelay == $past(regs.wrData[31:24]))
    else $error("power-good byte not stored");

  // byte-lane writes: strobed lanes land, others keep their value
  AST_THRESH_LANE: assert property (@(posedge mclk) disable iff (rst)
    regs.wrEn && regs.wrAddr == LS_THRESH_OFFSET && regs.wrStrb[0] |=>
    thresh_reg[7:0] == $past(regs.wrData[7:0]))
    else $error("threshold low byte not stored");
  AST_THRESH_KEEP: assert property (@(posedge mclk) disable iff (rst)
    regs.wrEn && regs.wrAddr == LS_THRESH_OFFSET && !regs.wrStrb[1] |=>
    thresh_reg[15:8] == $past(thresh_reg[15:8]))
    else $error("unstrobed threshold byte changed");
  // strap is caught once, on the first edge out of reset
  AST_PORT_STRAP: assert property (@(posedge mclk) disable iff (rst)
    !resetSeen_reg |=>
    portCount_reg == ($past(twoPortConfig) ? PORTS_TWO : PORTS_ONE))
    else $error("port count not taken from strap");
  AST_PORT_READ: assert property (@(posedge mclk) disable iff (rst)
    regs.rdAddr == RH_DESC_A_OFFSET |-> regs.rdData[7:0] == portCount_reg)
    else $error("port count byte not read back");
  AST_COLLECTIVE: assert property (@(posedge mclk) disable iff (rst)
    !descA_reg[NO_OC_BIT] && !descA_reg[OC_MODE_BIT] |->
    collectiveOvercurrent && !perPortOvercurrent)
    else $error("collective overcurrent not selected");
  // no start may leak out of a reset
  AST_START_RESET: assert property (@(posedge mclk) rst |=> !lowSpeedStart)
    else $error("low-speed start during reset");
endmodule

// file: tb.sv
// self-checking bench for the threshold and first root hub descriptor bank
// assumes the bank answers AXI4-Lite on mclk and samples the strap after reset
`timescale 1ns/1ps
module tb;
  import rh_regs_pkg::*;
  // clock, reset and bus
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  // strap, gate and policy
  logic        twoPortConfig = 1'b1;
  logic [13:0] frameTimeRemaining = 14'h0;
  logic        lowSpeedRequest = 1'b0;
  logic        lowSpeedStart;
  logic [7:0]  powerGoodDelay;
  logic        perPortOvercurrent;
  logic        collectiveOvercurrent;
  logic        perPortPower;
  logic        gangedPower;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          err_count = 0;
  int          n_tests = 0;

  always #25 mclk = ~mclk;

  lowspeed_threshold_roothub_desc_a dut (
    .mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .twoPortConfig(twoPortConfig), .frameTimeRemaining(frameTimeRemaining),
    .lowSpeedRequest(lowSpeedRequest), .lowSpeedStart(lowSpeedStart),
    .powerGoodDelay(powerGoodDelay), .perPortOvercurrent(perPortOvercurrent),
    .collectiveOvercurrent(collectiveOvercurrent), .perPortPower(perPortPower),
    .gangedPower(gangedPower));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // handshakes are judged at the falling edge, where the levels equal those of the next rise
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    logic hsAw, hsW, done;
    done = 1'b0;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(negedge mclk);
      hsAw = awvalid && awready;
      hsW  = wvalid && wready;
      if (bvalid && bready) begin
        resp = bresp;
        done = 1'b1;
      end
      @(posedge mclk);
      if (hsAw) awvalid <= 1'b0;
      if (hsW) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic hsAr, done;
    done = 1'b0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(negedge mclk);
      hsAr = arvalid && arready;
      if (rvalid && rready) begin
        d = rdata;
        resp = rresp;
        done = 1'b1;
      end
      @(posedge mclk);
      if (hsAr) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
  endtask

  task automatic read_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    axi_read(a, rd, rsp);
    chk(rd, exp);
    chk({30'h0, rsp}, {30'h0, er});
  endtask

  // policy outputs packed as delay, per-port oc, collective oc, per-port power, ganged
  task automatic pol_chk(input logic [11:0] exp);
    @(negedge mclk);
    chk({20'h0, powerGoodDelay, perPortOvercurrent, collectiveOvercurrent, perPortPower,
         gangedPower}, {20'h0, exp});
  endtask

  // start is registered: request at one edge, answer seen after the next
  task automatic gate_chk(input logic [13:0] fr, input logic req, input logic exp);
    @(posedge mclk);
    frameTimeRemaining <= fr;
    lowSpeedRequest    <= req;
    @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, lowSpeedStart}, {31'h0, exp});
  endtask

  task automatic do_reset(input logic two);
    @(posedge mclk);
    rst <= 1'b1;
    twoPortConfig <= two;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    print_verdict();
  end

  initial begin
    do_reset(1'b1);
    read_chk(LS_THRESH_OFFSET, 32'h00000628, RESP_OKAY);
    read_chk(RH_DESC_A_OFFSET, 32'hff000902, RESP_OKAY);
    pol_chk({8'hff, 4'b1010});
    $display("test reset_values done");
    // reserved upper bits written as zero, threshold in the twelve-bit field
    axi_write(LS_THRESH_OFFSET, 32'h00000100, 4'hf, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    gate_chk(14'h00ff, 1'b1, 1'b0);
    gate_chk(14'h0100, 1'b1, 1'b1);
    gate_chk(14'h3fff, 1'b1, 1'b1);
    gate_chk(14'h3fff, 1'b0, 1'b0);
    axi_write(LS_THRESH_OFFSET, 32'h000000ff, 4'h1, rsp);
    read_chk(LS_THRESH_OFFSET, 32'h000001ff, RESP_OKAY);
    gate_chk(14'h01fe, 1'b1, 1'b0);
    gate_chk(14'h01ff, 1'b1, 1'b1);
    $display("test lowspeed_gate done");
    // compound bit and port count ignore writes
    axi_write(RH_DESC_A_OFFSET, 32'h3c001cff, 4'hf, rsp);
    read_chk(RH_DESC_A_OFFSET, 32'h3c001802, RESP_OKAY);
    pol_chk({8'h3c, 4'b0001});
    axi_write(RH_DESC_A_OFFSET, 32'h01000300, 4'hf, rsp);
    read_chk(RH_DESC_A_OFFSET, 32'h01000302, RESP_OKAY);
    pol_chk({8'h01, 4'b0100});
    axi_write(RH_DESC_A_OFFSET, 32'h80000900, 4'h8, rsp);
    read_chk(RH_DESC_A_OFFSET, 32'h80000302, RESP_OKAY);
    axi_write(RH_DESC_A_OFFSET, 32'h80000900, 4'h2, rsp);
    pol_chk({8'h80, 4'b1010});
    $display("test descriptor_fields done");
    axi_write(CTRL_OFFSET, 32'h12345678, 4'hf, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    read_chk(CTRL_OFFSET, 32'h0, RESP_SLVERR);
    $display("test unmapped done");
    // second reset in mid-run with the single-port strap
    do_reset(1'b0);
    read_chk(RH_DESC_A_OFFSET, 32'hff000901, RESP_OKAY);
    read_chk(LS_THRESH_OFFSET, 32'h00000628, RESP_OKAY);
    gate_chk(14'h0627, 1'b1, 1'b0);
    gate_chk(14'h0628, 1'b1, 1'b1);
    $display("test single_port done");
    print_verdict();
  end
endmodule
